//--- dhrs_defines.vh
`ifndef DHRS_DEFINES_VH
`define DHRS_DEFINES_VH

// ---------------------------------------------------------------
// Clock
// ---------------------------------------------------------------
`define DHRS_CLK_HZ          25000000
`define DHRS_CLK_NS          40

// ---------------------------------------------------------------
// Spike filter bounds (ns)
// ---------------------------------------------------------------
`define DHRS_REJECT_NS       5000
`define DHRS_ACCEPT_NS       9000
`define DHRS_GLITCH_NS       5000

// ---------------------------------------------------------------
// Release periods (ms)
// ---------------------------------------------------------------
`define DHRS_REL_SLEEP_MS    5
`define DHRS_REL_AWAKE_MS    120
`define DHRS_BLANK_MS        120
`define DHRS_CMD_WAIT_MS     5
`define DHRS_WAKE_WAIT_MS    120

// ---------------------------------------------------------------
// Nonvolatile load
// ---------------------------------------------------------------
`define DHRS_NVM_WORDS       8
`define DHRS_NVM_AW          3
`define DHRS_NVM_DW          8

`endif

//--- dhrs_nvm_model.sv
`timescale 1ns/100ps
module dhrs_nvm_model (
  // Clock and read port
  input  wire       core_clk,
  input  wire       nvm_rd,
  input  wire [2:0] nvm_addr,
  // Content seed, changed per scenario to expose a missed reload
  input  wire [7:0] base,
  output reg  [7:0] nvm_rdata
);
  initial nvm_rdata = 8'h00;
  // Word settles mid-cycle after the strobe, ready at the next rising edge
  always @(negedge core_clk) if (nvm_rd) nvm_rdata <= base + {5'h00, nvm_addr};
endmodule

//--- dhrs_reset_seq.v
`timescale 1ns/100ps
`include "dhrs_defines.vh"

module dhrs_reset_seq #(
  parameter NVM_WORDS      = `DHRS_NVM_WORDS,
  parameter NVM_AW         = `DHRS_NVM_AW,
  parameter NVM_DW         = `DHRS_NVM_DW,
  parameter ACCEPT_CYC     = (`DHRS_ACCEPT_NS + `DHRS_CLK_NS - 1)
                             / `DHRS_CLK_NS,
  parameter GLITCH_CYC     = `DHRS_GLITCH_NS / `DHRS_CLK_NS,
  parameter SLEEP_REL_CYC  = `DHRS_REL_SLEEP_MS * (`DHRS_CLK_HZ / 1000),
  parameter AWAKE_REL_CYC  = `DHRS_REL_AWAKE_MS * (`DHRS_CLK_HZ / 1000),
  parameter BLANK_CYC      = `DHRS_BLANK_MS * (`DHRS_CLK_HZ / 1000)
) (
  // Clock and reset
  input  wire              core_clk,
  input  wire              resetn,
  // Reset pin from host
  input  wire              hw_reset_line_n,
  // Mode seen by the core
  input  wire              sleep_in,
  // Nonvolatile memory read port
  output reg  [NVM_AW-1:0] nvm_addr,
  output reg               nvm_rd,
  input  wire [NVM_DW-1:0] nvm_rdata,
  // Loaded settings
  output reg  [NVM_DW-1:0] id_byte0,
  output reg  [NVM_DW-1:0] id_byte1,
  output reg  [NVM_DW-1:0] id_byte2,
  output reg  [NVM_DW-1:0] common_voltage_setting,
  // Status
  output reg               core_reset,
  output reg               display_blank,
  output reg               nvm_loaded,
  output reg               release_done
);

  // ---------------------------------------------------------------
  // States
  // ---------------------------------------------------------------
  localparam ST_RUN   = 3'h0;
  localparam ST_HELD  = 3'h1;
  localparam ST_BLANK = 3'h2;
  localparam ST_LOAD  = 3'h3;
  localparam ST_WAIT  = 3'h4;

  // ---------------------------------------------------------------
  // Pin synchroniser
  // ---------------------------------------------------------------
  reg pin_meta_r;
  reg pin_sync_r;

  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pin_meta_r <= 1'b1;
      pin_sync_r <= 1'b1;
    end else begin
      pin_meta_r <= hw_reset_line_n;
      pin_sync_r <= pin_meta_r;
    end
  end

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  // cnt_r counts low width and blanking, glitch_r glitch width, rel_cnt_r release time
  reg [22:0]       cnt_r;
  reg [22:0]       rel_cnt_r;
  reg [15:0]       glitch_r;
  reg [2:0]        state_r;
  reg              was_awake_r;
  reg [NVM_AW:0]   ld_idx_r;
  reg              ld_pend_r;

  // ---------------------------------------------------------------
  // Release limit
  // ---------------------------------------------------------------
  // Two cycles are spent in the pin synchroniser before counting
  function [22:0] rel_limit;
    input awake;
    begin
      if (awake) begin
        rel_limit = AWAKE_REL_CYC[22:0] - 23'h2;
      end else begin
        rel_limit = SLEEP_REL_CYC[22:0] - 23'h2;
      end
    end
  endfunction

  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_r       <= ST_RUN;
      cnt_r         <= 23'h0;
      rel_cnt_r     <= 23'h0;
      glitch_r      <= 16'h0;
      was_awake_r   <= 1'b0;
      ld_idx_r      <= {(NVM_AW+1){1'b0}};
      ld_pend_r     <= 1'b0;
      nvm_addr      <= {NVM_AW{1'b0}};
      nvm_rd        <= 1'b0;
      id_byte0      <= {NVM_DW{1'b0}};
      id_byte1      <= {NVM_DW{1'b0}};
      id_byte2      <= {NVM_DW{1'b0}};
      common_voltage_setting <= {NVM_DW{1'b0}};
      core_reset    <= 1'b0;
      display_blank <= 1'b0;
      nvm_loaded    <= 1'b0;
      release_done  <= 1'b1;
    end else begin
      nvm_rd <= 1'b0;
      case (state_r)
        ST_RUN: begin
          // Low pulses shorter than the accept width never reach the core
          if (!pin_sync_r) begin
            if (cnt_r >= ACCEPT_CYC[22:0] - 23'h1) begin
              state_r       <= ST_HELD;
              cnt_r         <= 23'h0;
              glitch_r      <= 16'h0;
              was_awake_r   <= ~sleep_in;
              core_reset    <= 1'b1;
              display_blank <= 1'b1;
              release_done  <= 1'b0;
              nvm_loaded    <= 1'b0;
            end else begin
              cnt_r <= cnt_r + 23'h1;
            end
          end else begin
            cnt_r <= 23'h0;
          end
        end
        ST_HELD: begin
          // High must last a full glitch width to count as a release
          if (pin_sync_r) begin
            if (glitch_r >= GLITCH_CYC[15:0] - 16'h1) begin
              state_r   <= was_awake_r ? ST_BLANK : ST_LOAD;
              glitch_r  <= 16'h0;
              rel_cnt_r <= 23'h0;
              cnt_r     <= 23'h0;
              ld_idx_r  <= {(NVM_AW+1){1'b0}};
              ld_pend_r <= 1'b0;
            end else begin
              glitch_r <= glitch_r + 16'h1;
            end
          end else begin
            glitch_r <= 16'h0;
          end
        end
        ST_BLANK: begin
          // Awake start: blanking sequence runs before reload
          rel_cnt_r <= rel_cnt_r + 23'h1;
          if (cnt_r >= BLANK_CYC[22:0] - 23'h1
                       - NVM_WORDS[22:0]) begin
            state_r <= ST_LOAD;
          end else begin
            cnt_r <= cnt_r + 23'h1;
          end
        end
        ST_LOAD: begin
          // Reload identity and stored settings, one word per two cycles
          rel_cnt_r <= rel_cnt_r + 23'h1;
          if (ld_pend_r) begin
            ld_pend_r <= 1'b0;
            case (nvm_addr)
              3'h0:    id_byte0 <= nvm_rdata;
              3'h1:    id_byte1 <= nvm_rdata;
              3'h2:    id_byte2 <= nvm_rdata;
              3'h3:    common_voltage_setting <= nvm_rdata;
              default: ;
            endcase
            ld_idx_r <= ld_idx_r + {{NVM_AW{1'b0}}, 1'b1};
          end else if (ld_idx_r == NVM_WORDS[NVM_AW:0]) begin
            nvm_loaded <= 1'b1;
            core_reset <= 1'b0;
            state_r    <= ST_WAIT;
          end else begin
            nvm_addr  <= ld_idx_r[NVM_AW-1:0];
            nvm_rd    <= 1'b1;
            ld_pend_r <= 1'b1;
          end
        end
        ST_WAIT: begin
          // Hold blank until the release period ends
          rel_cnt_r <= rel_cnt_r + 23'h1;
          if (rel_cnt_r >= rel_limit(was_awake_r)) begin
            display_blank <= 1'b0;
            release_done  <= 1'b1;
            state_r       <= ST_RUN;
            cnt_r         <= 23'h0;
          end
        end
        default: begin
          state_r <= ST_RUN;
        end
      endcase
      // ---------------------------------------------------------------
      // New pulse during release
      // ---------------------------------------------------------------
      // Spikes are filtered here too, so a short one cannot strand
      // the sequence with the core still held
      if (state_r != ST_RUN && state_r != ST_HELD) begin
        if (pin_sync_r) begin
          glitch_r <= 16'h0;
        end else if (glitch_r >= ACCEPT_CYC[15:0] - 16'h1) begin
          state_r       <= ST_HELD;
          cnt_r         <= 23'h0;
          glitch_r      <= 16'h0;
          was_awake_r   <= ~sleep_in;
          core_reset    <= 1'b1;
          display_blank <= 1'b1;
          release_done  <= 1'b0;
          nvm_loaded    <= 1'b0;
        end else begin
          glitch_r <= glitch_r + 16'h1;
        end
      end
    end
  end

endmodule

//--- dhrs_reset_seq_properties.sv
`timescale 1ns/100ps
module dhrs_reset_seq_properties #(
  parameter ACCEPT_CYC    = 20,
  parameter GLITCH_CYC    = 10,
  parameter AWAKE_REL_CYC = 400
) (
  // Clock and reset
  input wire core_clk,
  input wire resetn,
  // Pin and status
  input wire hw_reset_line_n,
  input wire nvm_rd,
  input wire core_reset,
  input wire display_blank,
  input wire nvm_loaded,
  input wire release_done
);
  // Saturating run lengths of the raw pin
  reg [15:0] lo_cnt_r;
  reg [15:0] hi_cnt_r;
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      lo_cnt_r <= 16'h0000;
      hi_cnt_r <= 16'h0000;
    end else begin
      lo_cnt_r <= hw_reset_line_n ? 16'h0000
                : lo_cnt_r + (&lo_cnt_r ? 16'h0000 : 16'h0001);
      hi_cnt_r <= hw_reset_line_n ? hi_cnt_r + (&hi_cnt_r ? 16'h0000 : 16'h0001)
                : 16'h0000;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  sequence load_end_s;
    $fell(core_reset);
  endsequence
  blank_in_reset_a: assert property (core_reset |-> display_blank)
    else $error("blank low during reset");
  load_before_end_a: assert property (load_end_s |-> nvm_loaded)
    else $error("reset ended before load");
  rd_pulse_a: assert property (nvm_rd |=> !nvm_rd)
    else $error("read strobe longer than one cycle");
  accept_len_a: assert property ($rose(core_reset) |->
    $past(lo_cnt_r, 2) >= ACCEPT_CYC - 2)
    else $error("reset taken on short pulse");
  loaded_clear_a: assert property ($rose(core_reset) |-> !nvm_loaded)
    else $error("loaded flag not cleared");
  done_excl_a: assert property (display_blank |-> !release_done)
    else $error("done while blanked");
  glitch_hold_a: assert property ($rose(nvm_loaded) |->
    hi_cnt_r >= GLITCH_CYC)
    else $error("load before glitch window");
  rel_bound_a: assert property ($fell(display_blank) |->
    hi_cnt_r <= GLITCH_CYC + AWAKE_REL_CYC + 4)
    else $error("release period too long");
endmodule
bind dhrs_reset_seq dhrs_reset_seq_properties #(.ACCEPT_CYC(ACCEPT_CYC),
  .GLITCH_CYC(GLITCH_CYC), .AWAKE_REL_CYC(AWAKE_REL_CYC)) u_props (
  .core_clk(core_clk), .resetn(resetn), .hw_reset_line_n(hw_reset_line_n),
  .nvm_rd(nvm_rd), .core_reset(core_reset), .display_blank(display_blank),
  .nvm_loaded(nvm_loaded), .release_done(release_done));

//--- dhrs_reset_seq_tb_top.sv
`timescale 1ns/100ps
`define CHK(a, b) begin total_checks = total_checks + 1; if ((a) !== (b)) begin n_mismatch = n_mismatch + 1; $display("[ERR] %0t %h %h", $time, a, b); end end
module dhrs_reset_seq_tb_top;
  reg        core_clk = 0, resetn = 0, pin_n = 1, sleep_in = 0;
  reg  [7:0] base = 8'h00;
  wire [2:0] nvm_addr;
  wire [7:0] nvm_rdata, id0, id1, id2, cv;
  wire       nvm_rd, core_reset, display_blank, nvm_loaded, release_done;
  integer    n_mismatch = 0, total_checks = 0, n;
  initial forever #20 core_clk = ~core_clk;
  dhrs_reset_seq #(.ACCEPT_CYC(20), .GLITCH_CYC(10), .SLEEP_REL_CYC(200),
    .AWAKE_REL_CYC(400), .BLANK_CYC(300)) dut (.core_clk(core_clk),
    .resetn(resetn), .hw_reset_line_n(pin_n), .sleep_in(sleep_in),
    .nvm_addr(nvm_addr), .nvm_rd(nvm_rd), .nvm_rdata(nvm_rdata),
    .id_byte0(id0), .id_byte1(id1), .id_byte2(id2),
    .common_voltage_setting(cv), .core_reset(core_reset),
    .display_blank(display_blank), .nvm_loaded(nvm_loaded),
    .release_done(release_done));
  dhrs_nvm_model nvm (.core_clk(core_clk), .nvm_rd(nvm_rd),
    .nvm_addr(nvm_addr), .base(base), .nvm_rdata(nvm_rdata));
  task cyc(input integer k); begin repeat (k) @(posedge core_clk); #1; end endtask
  task final_report; begin
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  end endtask
  // Spike below the accept count leaves the core untouched
  task t_short; begin
    pin_n = 0; cyc(15); pin_n = 1; cyc(40);
    `CHK(core_reset, 1'b0)
    `CHK(release_done, 1'b1)
  end endtask
  // Held reset with a short high glitch, then timed release
  task t_seq(input s, input [7:0] b, input integer lim); begin
    sleep_in = s; base = b;
    pin_n = 0; cyc(30);
    `CHK(core_reset, 1'b1)
    pin_n = 1; cyc(3); pin_n = 0; cyc(10);
    `CHK(core_reset, 1'b1)
    `CHK(display_blank, 1'b1)
    // A spike well after release must neither restart nor stall it
    pin_n = 1; cyc(40); pin_n = 0; cyc(5); pin_n = 1; n = 45;
    // Host stays quiet until the release sequence reports done
    while (release_done !== 1'b1 && n < 2000) begin cyc(1); n = n + 1; end
    `CHK(n <= lim, 1'b1)
    `CHK(display_blank, 1'b0)
    `CHK(nvm_loaded, 1'b1)
    `CHK({id0, id1, id2, cv}, {b, b + 8'h01, b + 8'h02, b + 8'h03})
  end endtask
  initial begin
    cyc(16); resetn = 1; cyc(2);
    t_short;
    t_seq(1'b1, 8'h50, 218);
    t_seq(1'b0, 8'h60, 418);
    `CHK(n > 218, 1'b1)
    final_report;
  end
  initial begin #200000; n_mismatch = n_mismatch + 1; final_report; end
endmodule
